// ### test/tbsync_src_model.sv
// burst data source model driving the sync stage pins
`timescale 1ns/100ps
module tbsync_src_model
(
  input  wire logic slave_mode,             // data valid before each edge
  output logic      external_bit_timing_in, // bit timing clock, still between bursts
  output logic      serial_tx_data_in,      // serial data
  output logic      clock_enable_in         // burst enable
);
  initial
  begin
    external_bit_timing_in = 1'b0;
    serial_tx_data_in = 1'b0;
    clock_enable_in = 1'b0;
  end

  // one burst: enable first, then n bits msb first on an 80 ns clock
  task automatic burst(input logic [15:0] bits, input int n);
    clock_enable_in = 1'b1;
    serial_tx_data_in = 1'b0;
    #133.7;
    for (int i = n - 1; i >= 0; i--)
    begin
      if (slave_mode)
        serial_tx_data_in = bits[i];
      #40;
      external_bit_timing_in = 1'b1;
      if (!slave_mode)
        serial_tx_data_in = bits[i];
      #40;
      external_bit_timing_in = 1'b0;
    end
    // released line shows the inverse, never a stale value
    #80;
    serial_tx_data_in = ~serial_tx_data_in;
    clock_enable_in = 1'b0;
  endtask
endmodule

// ### test/tx_bit_sync_input_latch_tb.sv
// self-checking bench of the bit sync input stage
`timescale 1ns/100ps
`include "tbsync_defs.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tx_bit_sync_input_latch_tb;
  localparam logic [7:0] A_CLK = `TBSYNC_IDX_CLKSRC << 2;
  localparam logic [7:0] A_TST = `TBSYNC_IDX_TESTSEL << 2;
  localparam logic [7:0] A_ARM = `TBSYNC_IDX_ARM << 2;
  localparam logic [7:0] A_STS = `TBSYNC_IDX_STATUS << 2;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        external_bit_timing_in;
  logic        serial_tx_data_in;
  logic        clock_enable_in;
  logic        generated_bit_clock_out;
  logic        aux_free_running_clock;
  logic        symbol_pulse_out;
  logic        tx_bit_data;
  logic        tx_bit_valid;
  logic        tx_bit_ready;
  logic        slave_mode;
  logic        e_bit;
  logic        pa;
  logic        pb;
  logic [32:0] e_rd;
  logic [9:0]  lf;
  logic        bq[$];
  logic [32:0] rq[$];
  int          n_errors;
  int          num_checks;
  int          cyc;
  int          npop;
  int          skip;
  int          ready_mode;
  int          na;
  int          nb;

  tbsync_top u_dut
  (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_bit_timing_in(external_bit_timing_in), .serial_tx_data_in(serial_tx_data_in),
    .clock_enable_in(clock_enable_in), .generated_bit_clock_out(generated_bit_clock_out),
    .aux_free_running_clock(aux_free_running_clock), .symbol_pulse_out(symbol_pulse_out),
    .tx_bit_data(tx_bit_data), .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready)
  );

  tbsync_src_model u_src
  (
    .slave_mode(slave_mode),
    .external_bit_timing_in(external_bit_timing_in),
    .serial_tx_data_in(serial_tx_data_in),
    .clock_enable_in(clock_enable_in)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // sink ready: stalled, open or random
  always @(posedge clk)
    tx_bit_ready <= (ready_mode == 2) ? 1'($urandom) : (ready_mode == 1);

  // result watcher: oldest note against each taken bit and read answer
  always @(posedge clk)
  begin
    if (tx_bit_valid === 1'b1 && tx_bit_ready === 1'b1)
    begin
      npop++;
      // leading idle zeros and one early copy of the marker are tolerated
      if (!(skip == 2 && tx_bit_data !== 1'b1) && !(skip == 1 && tx_bit_data === 1'b1))
      begin
        if (bq.size() > 0)
        begin
          e_bit = bq.pop_front();
          `CHK("serial bit", e_bit, tx_bit_data)
        end
      end
      if (skip > 0 && !(skip == 2 && tx_bit_data !== 1'b1))
        skip--;
    end
    if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
    begin
      e_rd = rq.pop_front();
      `CHK("apb read", e_rd, {pslverr, prdata & 32'hfffffffb})
    end
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    // a slave that never answers counts as a mismatch
    if (t >= 50)
      n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    rq.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask

  // one burst with restart timing and bit stream checks
  task automatic run_burst;
    logic [7:0] b;
    int         d;
    ready_mode = 2;
    repeat (20) @(posedge clk);
    b = {2'b10, 5'($urandom), 1'b0};
    for (int i = 7; i >= 0; i--)
      bq.push_back(b[i]);
    skip = 2;
    fork
      u_src.burst({8'h00, b}, 8);
      begin
        @(posedge external_bit_timing_in);
        repeat (8) @(posedge clk);
        `CHK("restart level", 2'b11, {generated_bit_clock_out, symbol_pulse_out})
        d = 8;
        while (generated_bit_clock_out === 1'b1 && d < 16)
        begin
          @(posedge clk);
          d++;
        end
        `CHK("restart delay", 1'b1, d >= 9 && d <= 12)
      end
    join
    repeat (20) @(posedge clk);
    `CHK("bits left", 0, bq.size())
  endtask

  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_bit_ready = 1'b0;
    slave_mode = 1'b0;
    void'($urandom(67));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // reset values, then an unmapped offset
    rd(A_CLK, 32'h0, 1'b0);
    rd(A_TST, 32'h0, 1'b0);
    rd(A_STS, 32'h8, 1'b0);
    rd(8'h00, 32'h0, 1'b1);
    // enable low: bit clock still, aux clock free
    repeat (40)
    begin
      pa = aux_free_running_clock;
      pb = generated_bit_clock_out;
      @(posedge clk);
      na += int'(aux_free_running_clock !== pa);
      nb += int'(generated_bit_clock_out !== pb);
    end
    `CHK("aux toggles", 10, na)
    `CHK("bit clock toggles", 0, nb)
    // mode selection, test enable wins over clock source
    apb(1'b1, A_CLK, 32'hffffffff);
    rd(A_CLK, 32'h80, 1'b0);
    rd(A_STS, 32'h10, 1'b0);
    apb(1'b1, A_TST, 32'h1);
    rd(A_STS, 32'h20, 1'b0);
    apb(1'b1, A_TST, 32'h3);
    rd(A_TST, 32'h3, 1'b0);
    rd(A_STS, 32'h20, 1'b0);
    apb(1'b1, A_TST, 32'h0);
    apb(1'b1, A_CLK, 32'h0);
    // software arm pulse, then a master burst clears it
    apb(1'b1, A_ARM, 32'h1);
    apb(1'b1, A_ARM, 32'h0);
    rd(A_STS, 32'h9, 1'b0);
    run_burst();
    rd(A_STS, 32'h8, 1'b0);
    // slave capture
    apb(1'b1, A_CLK, 32'h80);
    slave_mode = 1'b1;
    run_burst();
    slave_mode = 1'b0;
    apb(1'b1, A_CLK, 32'h0);
    // fill the fifo with the sink stalled, then drain it
    ready_mode = 0;
    u_src.burst(16'h00a5, 8);
    `CHK("stall high", 1'b1, generated_bit_clock_out)
    repeat (10) @(posedge clk);
    npop = 0;
    ready_mode = 1;
    repeat (20) @(posedge clk);
    `CHK("drained", 4, npop)
    `CHK("empty", 1'b0, tx_bit_valid)
    // test mode: 10,3 sequence from an all-ones seed, no idle bits
    apb(1'b1, A_TST, 32'h1);
    lf = 10'h3ff;
    repeat (6)
    begin
      bq.push_back(lf[9] ^ lf[2]);
      lf = {lf[8:0], lf[9] ^ lf[2]};
    end
    u_src.burst(16'h0000, 8);
    repeat (20) @(posedge clk);
    `CHK("test bits left", 0, bq.size())
    apb(1'b1, A_TST, 32'h0);
    rd(A_STS, 32'h8, 1'b0);
    wrap_up();
  end
endmodule

// ### verilog/tbsync_defs.svh
// constants of the burst transmitter bit sync input stage
// Overview of operation
// - three capture modes: master, slave, test
// - clock source bit picks master or slave
// - test mode feeds selectable pseudo-random sequence
// - generated clock falling, external clock rising samples
// - bit clock stops while enable low
// - auxiliary clock always runs
// - slave bit recaptured on next falling edge
// - armed, first external rising edge triggers
// - arm on enable rise or software pulse
// - trigger restarts bit clock high, symbol start
// - restart two cycles after synchronised edge
`ifndef TBSYNC_DEFS_SVH
`define TBSYNC_DEFS_SVH

`define TBSYNC_IDX_CLKSRC  8'h2c
`define TBSYNC_IDX_TESTSEL 8'h2d
`define TBSYNC_IDX_ARM     8'h2e
`define TBSYNC_IDX_STATUS  8'h2f
`define TBSYNC_CLKSRC_BIT  7
`define TBSYNC_ARM_BIT     0
`define TBSYNC_DIV_W       8
`define TBSYNC_BCLK_HALF   8'h04
`define TBSYNC_ACLK_HALF   8'h04
`define TBSYNC_BPS         4'h2
`define TBSYNC_PN_SEED     23'h7fffff
`define TBSYNC_FIFO_W      1
`define TBSYNC_FIFO_D      4

`endif

// ### verilog/tbsync_fifo.sv
// shift-register fifo with registered head
`timescale 1ns/100ps
module tbsync_fifo #(parameter int W = 1, parameter int D = 4)
(
  input  wire logic   clk,   // system clock
  input  wire logic   nrst,  // async reset, active low
  tbsync_strm_if.fifo bus    // stream in and out
);
  typedef struct packed
  {
    logic [D-1:0][W-1:0] mem;
    logic [D-1:0]        vld;
  } tbsync_fifo_st_type;

  tbsync_fifo_st_type st_r;
  tbsync_fifo_st_type st_nxt;
  logic               put;

  // pop shifts toward the head, push fills first free slot
  always_comb
  begin
    st_nxt = st_r;
    put    = bus.in_valid && bus.in_ready;
    if (st_r.vld[0] && bus.out_ready)
    begin
      st_nxt.mem = {{W{1'b0}}, st_r.mem[D-1:1]};
      st_nxt.vld = {1'b0, st_r.vld[D-1:1]};
    end
    for (int i = 0; i < D; i++)
    begin
      if (put && !st_nxt.vld[i])
      begin
        st_nxt.mem[i] = bus.in_data;
        st_nxt.vld[i] = 1'b1;
        put           = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // full refuses even on a simultaneous pop: simpler, one bit slower
  assign bus.in_ready  = !st_r.vld[D-1];
  assign bus.out_valid = st_r.vld[0];
  assign bus.out_data  = st_r.mem[0];
endmodule

// ### verilog/tbsync_pkg.sv
// types of the bit sync input stage
`include "tbsync_defs.svh"
package tbsync_pkg;

  typedef enum logic [2:0]
  {
    MODE_MASTER = 3'h1,
    MODE_SLAVE  = 3'h2,
    MODE_TEST   = 3'h4
  } tbsync_mode_type;

  typedef enum logic [2:0]
  {
    ARM_IDLE  = 3'h1,
    ARM_ARMED = 3'h2,
    ARM_FIRE  = 3'h4
  } tbsync_arm_type;

  typedef struct packed
  {
    logic [`TBSYNC_DIV_W-1:0] div;
    logic                     bclk;
    logic [`TBSYNC_DIV_W-1:0] adiv;
    logic                     aclk;
    logic [3:0]               symcnt;
    logic                     sympls;
    tbsync_arm_type           arm;
    logic                     cken_d;
    logic                     ext_d;
    logic                     arm_prev;
    logic                     slave_bit;
    logic [22:0]              pn;
    logic                     push;
    logic                     push_data;
    logic                     clk_src;
    logic [1:0]               test_sel;
    logic                     arm_bit;
    logic                     ovf;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
  } tbsync_top_st_type;

endpackage

// ### verilog/tbsync_strm_if.sv
// captured bit stream between the sync logic and its fifo
`timescale 1ns/100ps
interface tbsync_strm_if #(parameter int W = 1);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport producer (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
  modport fifo     (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// ### verilog/tbsync_sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module tbsync_sync3 #(parameter int W = 1)
(
  input  wire logic         clk,    // system clock
  input  wire logic         nrst,   // async reset, active low
  input  wire logic [W-1:0] din,    // asynchronous input
  output logic      [W-1:0] dout    // filtered level
);
  typedef struct packed
  {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] lvl;
  } tbsync_s3_st_type;

  tbsync_s3_st_type st_r;
  tbsync_s3_st_type st_nxt;

  // ff1 only feeds ff2; level moves once ff2 and ff3 agree
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.ff1 = din;
    st_nxt.ff2 = st_r.ff1;
    st_nxt.ff3 = st_r.ff2;
    for (int i = 0; i < W; i++)
    begin
      if (st_r.ff2[i] == st_r.ff3[i])
        st_nxt.lvl[i] = st_r.ff3[i];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign dout = st_r.lvl;
endmodule

// ### verilog/tbsync_top.sv
// bit sync input stage: capture modes, arm and trigger, apb registers
`timescale 1ns/100ps
`include "tbsync_defs.svh"
module tbsync_top
(
  input  wire logic        clk,                     // 100 MHz master clock
  input  wire logic        nrst,                    // async reset, active low
  input  wire logic        psel,                    // apb select
  input  wire logic        penable,                 // apb access phase
  input  wire logic        pwrite,                  // apb direction
  input  wire logic [7:0]  paddr,                   // apb byte address
  input  wire logic [31:0] pwdata,                  // apb write data
  output logic      [31:0] prdata,                  // apb read data
  output logic             pready,                  // apb ready
  output logic             pslverr,                 // apb error, unmapped
  input  wire logic        external_bit_timing_in,  // external bit timing clock pin
  input  wire logic        serial_tx_data_in,       // serial transmit data pin
  input  wire logic        clock_enable_in,         // clock enable pin
  output logic             generated_bit_clock_out, // generated bit clock
  output logic             aux_free_running_clock,  // free running auxiliary clock
  output logic             symbol_pulse_out,        // high during first bit of symbol
  output logic             tx_bit_data,             // captured bit to encoder
  output logic             tx_bit_valid,            // captured bit present
  input  wire logic        tx_bit_ready             // encoder takes bit
);
  localparam logic [7:0] A_CLKSRC  = 8'(`TBSYNC_IDX_CLKSRC * 4);
  localparam logic [7:0] A_TESTSEL = 8'(`TBSYNC_IDX_TESTSEL * 4);
  localparam logic [7:0] A_ARM     = 8'(`TBSYNC_IDX_ARM * 4);
  localparam logic [7:0] A_STATUS  = 8'(`TBSYNC_IDX_STATUS * 4);
  localparam logic [`TBSYNC_DIV_W-1:0] BCLK_LAST = `TBSYNC_BCLK_HALF - 8'h01;
  localparam logic [`TBSYNC_DIV_W-1:0] ACLK_LAST = `TBSYNC_ACLK_HALF - 8'h01;
  localparam logic [3:0] SYM_LAST = `TBSYNC_BPS - 4'h1;

  tbsync_pkg::tbsync_top_st_type st_r;
  tbsync_pkg::tbsync_top_st_type st_nxt;
  tbsync_pkg::tbsync_mode_type   mode;
  logic [2:0]                    pin_s;
  logic                          ext_s;
  logic                          data_s;
  logic                          cken_s;
  logic                          ext_rise;
  logic                          cken_rise;
  logic                          sw_arm;
  logic                          fall;
  logic                          pn_fb;
  logic                          acc;
  logic                          cap_bit;

  tbsync_strm_if #(.W(`TBSYNC_FIFO_W)) bus ();

  // all three pins come from outside the clock domain
  tbsync_sync3 #(.W(3)) u_sync
  (
    .clk  (clk),
    .nrst (nrst),
    .din  ({clock_enable_in, serial_tx_data_in, external_bit_timing_in}),
    .dout (pin_s)
  );

  tbsync_fifo #(.W(`TBSYNC_FIFO_W), .D(`TBSYNC_FIFO_D)) u_fifo
  (
    .clk  (clk),
    .nrst (nrst),
    .bus  (bus)
  );

  assign ext_s     = pin_s[0];
  assign data_s    = pin_s[1];
  assign cken_s    = pin_s[2];
  assign ext_rise  = ext_s && !st_r.ext_d;
  assign cken_rise = cken_s && !st_r.cken_d;
  assign sw_arm    = st_r.arm_prev && !st_r.arm_bit; // high then low again
  assign acc       = psel && penable;

  // test select wins over clock source; test always uses own clock
  always_comb
  begin
    if (st_r.test_sel[0])
      mode = tbsync_pkg::MODE_TEST;
    else if (st_r.clk_src)
      mode = tbsync_pkg::MODE_SLAVE;
    else
      mode = tbsync_pkg::MODE_MASTER;
  end

  // 23,18 sequence when upper select bit set, else 10,3
  assign pn_fb = st_r.test_sel[1] ? (st_r.pn[22] ^ st_r.pn[17])
                                  : (st_r.pn[9] ^ st_r.pn[2]);

  always_comb
  begin
    st_nxt         = st_r;
    fall           = 1'b0;
    cap_bit        = 1'b0;
    st_nxt.push    = 1'b0;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = '0;

    // apb: answer one cycle into access phase, write at ready edge
    if (acc && !st_r.pready)
    begin
      st_nxt.pready = 1'b1;
      case (paddr)
        A_CLKSRC:  st_nxt.prdata[`TBSYNC_CLKSRC_BIT] = st_r.clk_src;
        A_TESTSEL: st_nxt.prdata[1:0] = st_r.test_sel;
        A_ARM:     st_nxt.prdata[`TBSYNC_ARM_BIT] = st_r.arm_bit;
        A_STATUS:  st_nxt.prdata[5:0] = {mode, st_r.bclk, st_r.ovf,
                                         st_r.arm == tbsync_pkg::ARM_ARMED};
        default:   st_nxt.pslverr = 1'b1;
      endcase
    end
    if (acc && st_r.pready && pwrite && !st_r.pslverr)
    begin
      case (paddr)
        A_CLKSRC:  st_nxt.clk_src = pwdata[`TBSYNC_CLKSRC_BIT];
        A_TESTSEL: st_nxt.test_sel = pwdata[1:0];
        A_ARM:     st_nxt.arm_bit = pwdata[`TBSYNC_ARM_BIT];
        A_STATUS:  st_nxt.ovf = st_r.ovf && !pwdata[1];
        default:   st_nxt.ovf = st_r.ovf;
      endcase
    end

    // auxiliary clock ignores enable and sync, runs between bursts
    if (st_r.adiv == ACLK_LAST)
    begin
      st_nxt.adiv = '0;
      st_nxt.aclk = !st_r.aclk;
    end
    else
      st_nxt.adiv = st_r.adiv + 8'h01;

    // bit clock: restart on trigger, stop while disabled, stall on full fifo
    if (st_r.arm == tbsync_pkg::ARM_FIRE)
    begin
      st_nxt.div    = '0;
      st_nxt.bclk   = 1'b1;
      st_nxt.symcnt = '0;
      st_nxt.sympls = 1'b1;
    end
    else if (cken_s)
    begin
      if (st_r.div != BCLK_LAST)
        st_nxt.div = st_r.div + 8'h01;
      else if (!(st_r.bclk && !bus.in_ready))
      begin
        st_nxt.div  = '0;
        st_nxt.bclk = !st_r.bclk;
        fall        = st_r.bclk;
      end
    end

    // capture on falling edge of the generated clock
    if (fall)
    begin
      st_nxt.symcnt = (st_r.symcnt == SYM_LAST) ? 4'h0 : st_r.symcnt + 4'h1;
      st_nxt.sympls = (st_r.symcnt == SYM_LAST);
      case (mode)
        tbsync_pkg::MODE_TEST:
        begin
          cap_bit   = pn_fb;
          st_nxt.pn = {st_r.pn[21:0], pn_fb};
        end
        tbsync_pkg::MODE_SLAVE:  cap_bit = st_r.slave_bit;
        tbsync_pkg::MODE_MASTER: cap_bit = data_s;
        default:                 cap_bit = data_s;
      endcase
      st_nxt.push      = 1'b1;
      st_nxt.push_data = cap_bit;
    end

    // slave data first caught on rising external edge
    if (ext_rise)
      st_nxt.slave_bit = data_s;

    // lost bit flag; set wins over the software clear
    if (st_r.push && !bus.in_ready)
      st_nxt.ovf = 1'b1;

    // arm and trigger
    st_nxt.cken_d   = cken_s;
    st_nxt.ext_d    = ext_s;
    st_nxt.arm_prev = st_r.arm_bit;
    case (st_r.arm)
      tbsync_pkg::ARM_IDLE:
      begin
        if (cken_rise || sw_arm)
          st_nxt.arm = tbsync_pkg::ARM_ARMED;
      end
      tbsync_pkg::ARM_ARMED:
      begin
        if (ext_rise)
          st_nxt.arm = tbsync_pkg::ARM_FIRE;
      end
      tbsync_pkg::ARM_FIRE:
      begin
        // arm cleared by trigger unless re-armed right now
        st_nxt.arm = (cken_rise || sw_arm) ? tbsync_pkg::ARM_ARMED
                                           : tbsync_pkg::ARM_IDLE;
      end
      default: st_nxt.arm = tbsync_pkg::ARM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r     <= '0;
      st_r.arm <= tbsync_pkg::ARM_IDLE;
      st_r.pn  <= `TBSYNC_PN_SEED;
    end
    else
      st_r <= st_nxt;
  end

  // stream into the fifo; the encoder drains it
  assign bus.in_valid  = st_r.push;
  assign bus.in_data   = st_r.push_data;
  assign bus.out_ready = tx_bit_ready;

  // outputs, all straight from flops
  assign prdata                  = st_r.prdata;
  assign pready                  = st_r.pready;
  assign pslverr                 = st_r.pslverr;
  assign generated_bit_clock_out = st_r.bclk;
  assign aux_free_running_clock  = st_r.aclk;
  assign symbol_pulse_out        = st_r.sympls;
  assign tx_bit_data             = bus.out_data;
  assign tx_bit_valid            = bus.out_valid;

  // checks
  localparam int AUX_LIM = `TBSYNC_ACLK_HALF;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence seq_trig;
    st_r.arm == tbsync_pkg::ARM_ARMED && ext_rise;
  endsequence

  sequence seq_restart;
    st_r.arm == tbsync_pkg::ARM_FIRE ##1 generated_bit_clock_out && st_r.symcnt == 4'h0;
  endsequence

  bclk_stop_a: assert property (!cken_s && st_r.arm != tbsync_pkg::ARM_FIRE
    |=> $stable(generated_bit_clock_out)) else $error("bit clock moved while disabled");

  aux_runs_a: assert property ($changed(aux_free_running_clock)
    |-> ##[1:AUX_LIM] $changed(aux_free_running_clock)) else $error("aux clock stalled");

  trig_restart_a: assert property (seq_trig |=> seq_restart)
    else $error("trigger did not restart counters");

  restart_dly_a: assert property (seq_trig |-> ##2 generated_bit_clock_out && symbol_pulse_out)
    else $error("restart not two cycles after detected edge");

  trig_disarm_a: assert property (seq_trig ##1 !(cken_rise || sw_arm)
    |=> st_r.arm == tbsync_pkg::ARM_IDLE) else $error("arm not cleared by trigger");

  arm_cause_a: assert property (st_r.arm == tbsync_pkg::ARM_IDLE && (cken_rise || sw_arm)
    |=> st_r.arm == tbsync_pkg::ARM_ARMED) else $error("arm request lost");

  mode_sel_a: assert property (!st_r.test_sel[0]
    |-> (mode == tbsync_pkg::MODE_SLAVE) == st_r.clk_src) else $error("wrong capture mode");

  master_cap_a: assert property (fall && mode == tbsync_pkg::MODE_MASTER
    |=> st_r.push && st_r.push_data == $past(data_s)) else $error("master bit not captured");

  slave_cap_a: assert property (fall && mode == tbsync_pkg::MODE_SLAVE
    |=> st_r.push_data == $past(st_r.slave_bit)) else $error("slave bit not recaptured");

  pn_cap_a: assert property (fall && mode == tbsync_pkg::MODE_TEST
    |=> st_r.push_data == $past(pn_fb) && st_r.pn[0] == $past(pn_fb))
    else $error("test sequence bit wrong");
endmodule
